// File: rtl/lbc_pkg.sv
// ==========================================================================
// logic block cell slice: shared constants and types
package lbc_pkg;

  // ========================================================================
  // sizes
  localparam int LBC_CELLS   = 6;
  localparam int LBC_MCELLS  = 2 * LBC_CELLS;
  localparam int LBC_CLKS    = 4;
  localparam int LBC_OE_TERMS = 2;
  localparam int LBC_ADDR_W  = 8;
  localparam int LBC_DATA_W  = 32;
  localparam int LBC_MC_CFG_W = 8;
  localparam int LBC_IO_CFG_W = 3;

  // ========================================================================
  // register offsets (byte addresses, one word each)
  localparam logic [LBC_ADDR_W-1:0] LBC_MC_CFG_BASE = 8'h00;
  localparam logic [LBC_ADDR_W-1:0] LBC_IO_CFG_BASE = 8'h30;
  localparam logic [LBC_ADDR_W-1:0] LBC_STATE_OFS   = 8'h48;
  localparam logic [LBC_ADDR_W-1:0] LBC_PIN_OFS     = 8'h4C;
  localparam logic [LBC_ADDR_W-1:0] LBC_WORD_STEP   = 8'h04;

  // ========================================================================
  // modes
  typedef enum logic [2:0] {
    LBC_COMB,
    LBC_REG,
    LBC_LATCH,
    LBC_IN_REG,
    LBC_IN_LATCH
  } lbc_mode_t;

  typedef enum logic [1:0] {
    LBC_OE_OFF,
    LBC_OE_ON,
    LBC_OE_TERM
  } lbc_oe_t;

  // ========================================================================
  // configuration words, low bit first from the right
  typedef struct packed {
    logic      low_pwr;
    logic [1:0] clk_sel;
    logic      t_type;
    logic      invert;
    lbc_mode_t mode;
  } lbc_mc_cfg_t;

  typedef struct packed {
    logic    oe_sel;
    lbc_oe_t oe_mode;
  } lbc_io_cfg_t;

  // product-term results arriving from the array
  typedef struct packed {
    logic [LBC_MCELLS-1:0]   sum;
    logic [LBC_OE_TERMS-1:0] oe;
    logic                    rst;
    logic                    pre;
  } lbc_terms_t;

  // ========================================================================
  // whole module state
  typedef struct packed {
    lbc_mc_cfg_t [LBC_MCELLS-1:0] mc_cfg;
    lbc_io_cfg_t [LBC_CELLS-1:0]  io_cfg;
    logic [LBC_MCELLS-1:0]        store;
    logic [LBC_MCELLS-1:0]        lp_pipe;
    logic [LBC_MCELLS-1:0]        fb;
    logic [LBC_CELLS-1:0]         keep;
    logic [LBC_CELLS-1:0]         io_out;
    logic [LBC_CELLS-1:0]         io_oe_b;
    logic [LBC_CELLS-1:0]         io_fb;
    logic [LBC_CLKS-1:0]          clk_keep;
    logic [LBC_CLKS-1:0]          clk_prev;
    logic [LBC_CLKS-1:0]          clk_data;
    logic [LBC_DATA_W-1:0]        rdata;
  } lbc_state_t;

  localparam lbc_state_t LBC_STATE_RST = '{
    mc_cfg:   '0,
    io_cfg:   '0,
    store:    '0,
    lp_pipe:  '0,
    fb:       '0,
    keep:     '0,
    io_out:   '0,
    io_oe_b:  '1,
    io_fb:    '0,
    clk_keep: '0,
    clk_prev: '0,
    clk_data: '0,
    rdata:    '0
  };

endpackage : lbc_pkg

// File: rtl/lbc_cell_slice.sv
`timescale 1ns/1ps

module lbc_cell_slice
  import lbc_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic [LBC_ADDR_W-1:0]  addr_i,
  input  wire logic [LBC_DATA_W-1:0]  wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [LBC_DATA_W-1:0]  rdata_o,
  input  wire lbc_terms_t             terms_i,
  input  wire logic [LBC_CLKS-1:0]    clk_pin_i,
  input  wire logic [LBC_CLKS-1:0]    clk_float_i,
  input  wire logic [LBC_CELLS-1:0]   io_in_i,
  input  wire logic [LBC_CELLS-1:0]   io_float_i,
  output logic      [LBC_CELLS-1:0]   io_out_o,
  output logic      [LBC_CELLS-1:0]   io_oe_b_o,
  output logic      [LBC_CELLS-1:0]   io_fb_o,
  output logic      [LBC_MCELLS-1:0]  fb_o,
  output logic      [LBC_CLKS-1:0]    clk_data_o
);

  // ========================================================================
  // one macrocell: returns {next stored value, result}
  function automatic logic [1:0] lbc_cell(
    input lbc_mc_cfg_t c,
    input logic        buried,
    input logic        d,
    input logic        st,
    input logic        pin,
    input logic        rise,
    input logic        gate,
    input logic        rst,
    input logic        pre
  );
    logic ns;
    logic res;
    logic stored;
    ns     = st;
    res    = d;
    stored = 1'b1;
    case (c.mode)
      LBC_REG: begin
        if (rise) begin
          ns = c.t_type ? (st ^ d) : d;
        end
        res = st;
      end
      LBC_LATCH: begin
        if (!gate) begin
          ns = d;
        end
        res = gate ? st : d;
      end
      LBC_IN_REG: begin
        if (buried) begin
          if (rise) begin
            ns = pin;
          end
          res = st;
        end else begin
          stored = 1'b0;
        end
      end
      LBC_IN_LATCH: begin
        if (buried) begin
          if (!gate) begin
            ns = pin;
          end
          res = gate ? st : pin;
        end else begin
          stored = 1'b0;
        end
      end
      default: begin
        stored = 1'b0;
      end
    endcase
    // reset wins over preset, applied the same cycle
    if (rst) begin
      ns = 1'b0;
      if (stored) begin
        res = 1'b0;
      end
    end else if (pre) begin
      ns = 1'b1;
      if (stored) begin
        res = 1'b1;
      end
    end
    return {ns, res ^ c.invert};
  endfunction : lbc_cell

  // ========================================================================
  // state
  lbc_state_t q;
  lbc_state_t next_q;

  logic [LBC_CLKS-1:0]   clk_lvl;
  logic [LBC_CLKS-1:0]   clk_rise;
  logic [LBC_CELLS-1:0]  pin_lvl;
  logic [LBC_MCELLS-1:0] cell_final;

  always_comb begin
    logic [1:0]            cr;
    logic                  en;
    logic [LBC_MCELLS-1:0] res;
    logic [LBC_DATA_W-1:0] rd;
    cr     = 2'b00;
    en     = 1'b0;
    res    = '0;
    rd     = '0;
    next_q = q;

    // keeper holds last level when nobody drives the pin
    for (int k = 0; k < LBC_CELLS; k++) begin
      if (!q.io_oe_b[k]) begin
        pin_lvl[k] = q.io_out[k];
      end else if (io_float_i[k]) begin
        pin_lvl[k] = q.keep[k];
      end else begin
        pin_lvl[k] = io_in_i[k];
      end
    end
    for (int j = 0; j < LBC_CLKS; j++) begin
      clk_lvl[j] = clk_float_i[j] ? q.clk_keep[j] : clk_pin_i[j];
    end
    clk_rise        = clk_lvl & ~q.clk_prev;
    next_q.keep     = pin_lvl;
    next_q.clk_keep = clk_lvl;
    next_q.clk_prev = clk_lvl;
    next_q.io_fb    = pin_lvl;
    // clock pins double as data inputs
    next_q.clk_data = clk_lvl;

    // six output cells then six buried cells
    for (int i = 0; i < LBC_MCELLS; i++) begin
      // one reset and one preset for the whole block
      cr = lbc_cell(q.mc_cfg[i], i >= LBC_CELLS, terms_i.sum[i], q.store[i],
                    pin_lvl[i % LBC_CELLS], clk_rise[q.mc_cfg[i].clk_sel],
                    clk_lvl[q.mc_cfg[i].clk_sel], terms_i.rst, terms_i.pre);
      next_q.store[i] = cr[1];
      res[i]          = cr[0];
    end
    // low-power paths pay one extra cycle, the others bypass it
    next_q.lp_pipe = res;
    for (int i = 0; i < LBC_MCELLS; i++) begin
      cell_final[i] = q.mc_cfg[i].low_pwr ? q.lp_pipe[i] : res[i];
    end
    next_q.fb = cell_final;
    // only output cells reach a pin
    next_q.io_out = cell_final[LBC_CELLS-1:0];

    for (int k = 0; k < LBC_CELLS; k++) begin
      case (q.io_cfg[k].oe_mode)
        LBC_OE_ON: begin
          en = 1'b1;
        end
        // one of two shared enable terms
        LBC_OE_TERM: begin
          en = terms_i.oe[q.io_cfg[k].oe_sel];
        end
        default: begin
          en = 1'b0;
        end
      endcase
      next_q.io_oe_b[k] = ~en;
    end

    // register writes
    if (wr_i) begin
      for (int i = 0; i < LBC_MCELLS; i++) begin
        if (addr_i == LBC_MC_CFG_BASE + LBC_ADDR_W'(i) * LBC_WORD_STEP) begin
          next_q.mc_cfg[i] = lbc_mc_cfg_t'(wdata_i[LBC_MC_CFG_W-1:0]);
        end
      end
      for (int k = 0; k < LBC_CELLS; k++) begin
        if (addr_i == LBC_IO_CFG_BASE + LBC_ADDR_W'(k) * LBC_WORD_STEP) begin
          next_q.io_cfg[k] = lbc_io_cfg_t'(wdata_i[LBC_IO_CFG_W-1:0]);
        end
      end
    end

    // register reads; unmapped addresses read zero
    for (int i = 0; i < LBC_MCELLS; i++) begin
      if (addr_i == LBC_MC_CFG_BASE + LBC_ADDR_W'(i) * LBC_WORD_STEP) begin
        rd[LBC_MC_CFG_W-1:0] = q.mc_cfg[i];
      end
    end
    for (int k = 0; k < LBC_CELLS; k++) begin
      if (addr_i == LBC_IO_CFG_BASE + LBC_ADDR_W'(k) * LBC_WORD_STEP) begin
        rd[LBC_IO_CFG_W-1:0] = q.io_cfg[k];
      end
    end
    if (addr_i == LBC_STATE_OFS) begin
      rd[LBC_MCELLS-1:0] = q.store;
    end
    if (addr_i == LBC_PIN_OFS) begin
      rd[LBC_CELLS+LBC_CLKS-1:0] = {q.clk_data, q.io_fb};
    end
    // read data stand for one cycle only
    next_q.rdata = rd_i ? rd : '0;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= LBC_STATE_RST;
    end else begin
      q <= next_q;
    end
  end

  assign rdata_o    = q.rdata;
  assign io_out_o   = q.io_out;
  assign io_oe_b_o  = q.io_oe_b;
  assign io_fb_o    = q.io_fb;
  assign fb_o       = q.fb;
  assign clk_data_o = q.clk_data;

  // ========================================================================
  // checks
  // each check watches the cell that the bench sets to that mode, except oe_term_pick_a: the bench sets pin 0 to always on, not to a term
  logic sel_rise1;
  logic sel_gate3;
  logic sel_rise7;
  logic oe_pick0;
  logic no_force;

  assign sel_rise1 = clk_rise[q.mc_cfg[1].clk_sel];
  assign sel_gate3 = clk_lvl[q.mc_cfg[3].clk_sel];
  assign sel_rise7 = clk_rise[q.mc_cfg[LBC_CELLS+1].clk_sel];
  assign oe_pick0  = terms_i.oe[q.io_cfg[0].oe_sel];
  assign no_force  = !terms_i.rst && !terms_i.pre;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  oe_forced_off_a: assert property (
    (q.io_cfg[0].oe_mode == LBC_OE_OFF) |=> io_oe_b_o[0])
    else $error("driver enabled while forced off");

  oe_term_pick_a: assert property (
    (q.io_cfg[0].oe_mode == LBC_OE_TERM) |=> (io_oe_b_o[0] == !$past(oe_pick0)))
    else $error("driver enable does not follow chosen term");

  dff_sample_a: assert property (
    (q.mc_cfg[1].mode == LBC_REG && !q.mc_cfg[1].t_type && sel_rise1 && no_force)
    |=> (q.store[1] == $past(terms_i.sum[1])))
    else $error("D register missed its rising edge");

  tff_hold_a: assert property (
    (q.mc_cfg[2].mode == LBC_REG && q.mc_cfg[2].t_type && !terms_i.sum[2] && no_force)
    |=> $stable(q.store[2]))
    else $error("T register changed with low input");

  latch_hold_a: assert property (
    (q.mc_cfg[3].mode == LBC_LATCH && sel_gate3 && no_force) |=> $stable(q.store[3]))
    else $error("latch changed while gate high");

  block_init_a: assert property (
    terms_i.rst |=> (q.store == '0))
    else $error("block storage not cleared together");

  block_preset_a: assert property (
    (terms_i.pre && !terms_i.rst) |=> (&q.store))
    else $error("block storage not preset");

  comb_invert_a: assert property (
    (q.mc_cfg[1].mode == LBC_COMB && !q.mc_cfg[1].low_pwr && q.mc_cfg[1].invert)
    |=> (fb_o[1] == !$past(terms_i.sum[1])) && (io_out_o[1] == fb_o[1]))
    else $error("inverted combinatorial path wrong");

  low_power_a: assert property (
    (q.mc_cfg[0].mode == LBC_COMB && q.mc_cfg[0].low_pwr && !q.mc_cfg[0].invert) [*2]
    |=> (fb_o[0] == $past(terms_i.sum[0], 2)))
    else $error("low-power path delay wrong");

  in_reg_a: assert property (
    (q.mc_cfg[LBC_CELLS+1].mode == LBC_IN_REG && sel_rise7 && no_force)
    |=> (q.store[LBC_CELLS+1] == $past(pin_lvl[1])))
    else $error("input register missed pin");

  keeper_hold_a: assert property (
    (io_oe_b_o[0] && io_float_i[0]) |=> (io_fb_o[0] == $past(io_fb_o[0])))
    else $error("floating pin lost its level");

endmodule : lbc_cell_slice

// File: testbench/lbc_board.sv
`timescale 1ns/1ps
// ==========
// board logic on the far side of the I/O pins
module lbc_board
  import lbc_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic [LBC_CELLS-1:0] drv_i,
  input  wire logic [LBC_CELLS-1:0] val_i,
  input  wire logic [LBC_CELLS-1:0] io_oe_b_i,
  output logic      [LBC_CELLS-1:0] io_in_o,
  output logic      [LBC_CELLS-1:0] io_float_o
);
  logic [LBC_CELLS-1:0] last;
  initial begin
    last       = '0;
    io_in_o    = '1;
    io_float_o = '1;
  end
  // a released pin shows the inverse level, so only the keeper can hold it
  always @(posedge clk_i) begin
    for (int k = 0; k < LBC_CELLS; k++) begin
      if (drv_i[k] && io_oe_b_i[k]) begin
        io_in_o[k]    <= val_i[k];
        last[k]       <= val_i[k];
        io_float_o[k] <= 1'b0;
      end else begin
        io_in_o[k]    <= ~last[k];
        io_float_o[k] <= 1'b1;
      end
    end
  end
endmodule : lbc_board

// File: testbench/lbc_cell_slice_tb.sv
`timescale 1ns/1ps
module lbc_cell_slice_tb;
  import lbc_pkg::*;
  typedef struct {int sel; string nm; logic [31:0] m; logic [31:0] e;} lbc_note_t;
  logic                  clk = 0, rst_b = 0, wr = 0, rd = 0, look = 0, rd_seen = 0;
  logic [LBC_ADDR_W-1:0] addr = '0;
  logic [31:0]           wdata = '0, rdata, r;
  lbc_terms_t            terms = '0;
  logic [LBC_CLKS-1:0]   cpin = '0, cdata;
  logic [LBC_CELLS-1:0]  drv = '0, val = '0, io_in, io_fl, io_out, io_oe_b, io_fb;
  logic [LBC_MCELLS-1:0] fb, inv;
  lbc_note_t             notes[$];
  int                    mismatches = 0, cmp_count = 0, cycles = 0;

  always #12.5 clk = ~clk;
  lbc_cell_slice uut (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .terms_i(terms), .clk_pin_i(cpin),
    .clk_float_i('0), .io_in_i(io_in), .io_float_i(io_fl), .io_out_o(io_out),
    .io_oe_b_o(io_oe_b), .io_fb_o(io_fb), .fb_o(fb), .clk_data_o(cdata));
  lbc_board board (.clk_i(clk), .drv_i(drv), .val_i(val), .io_oe_b_i(io_oe_b),
    .io_in_o(io_in), .io_float_o(io_fl));

  // ==========
  // checking
  task automatic results;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task automatic cmp(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin : mon
    lbc_note_t n;
    logic [31:0] s;
    if (rd_seen || look) begin
      n = notes.pop_front();
      case (n.sel)
        0: s = rdata;
        1: s = 32'(fb);
        2: s = 32'(io_out);
        default: s = 32'(io_oe_b);
      endcase
      cmp(n.nm, s & n.m, n.e & n.m);
    end
  end
  // hang guard, far above the two hundred or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  // ==========
  // drivers
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    notes.push_back('{0, nm, m, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  // settle wait covers the extra low-power stage
  task automatic see(input string nm, input int sel, input logic [31:0] m, e);
    repeat (4) @(posedge clk);
    look <= 1'b1;
    notes.push_back('{sel, nm, m, e});
    @(posedge clk);
    look <= 1'b0;
  endtask : see
  task automatic pulse(input int p);
    repeat (3) @(posedge clk);
    cpin[p] <= 1'b1;
    repeat (3) @(posedge clk);
    cpin[p] <= 1'b0;
  endtask : pulse
  function automatic logic [31:0] mc(lbc_mode_t md, logic iv, t, logic [1:0] cs, logic lp);
    return 32'({lp, cs, t, iv, md});
  endfunction : mc

  // ==========
  // scenarios
  initial begin
    void'($urandom(67));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg("cfg0", 8'h00, '1, '0);
    rd_reg("unmapped", 8'hFC, '1, '0);
    see("oe_reset", 3, 32'h3F, 32'h3F);
    r   = $urandom();
    inv = 12'(r >> 12);
    inv[1:0] = 2'b10;
    for (int i = 0; i < LBC_MCELLS; i++) wr_reg(8'(4 * i), mc(LBC_COMB, inv[i], 0, 0, i == 0));
    @(posedge clk) terms.sum <= r[11:0];
    see("comb_fb", 1, 32'hFFF, 32'(r[11:0] ^ inv));
    see("comb_pin", 2, 32'h3F, 32'(r[5:0] ^ inv[5:0]));
    @(posedge clk) terms.sum <= '0;
    see("comb_zero", 1, 32'hFFF, 32'(inv));
    wr_reg(8'h04, mc(LBC_REG, 0, 0, 2, 0));
    @(posedge clk) terms.rst <= 1'b1;
    @(posedge clk) terms.rst <= 1'b0;
    @(posedge clk) terms.sum[1] <= 1'b1;
    see("reg_idle", 1, 32'h2, 32'h0);
    pulse(0);
    see("reg_other", 1, 32'h2, 32'h0);
    pulse(2);
    see("reg_d", 1, 32'h2, 32'h2);
    @(posedge clk) terms.sum[1] <= 1'b0;
    see("reg_keep", 1, 32'h2, 32'h2);
    @(posedge clk) cpin <= 4'hA;
    rd_reg("clk_data", LBC_PIN_OFS, 32'h3C0, 32'h280);
    @(posedge clk) cpin <= 4'h0;
    @(posedge clk) terms.pre <= 1'b1;
    see("preset", 1, 32'h2, 32'h2);
    rd_reg("pre_all", LBC_STATE_OFS, 32'hFFF, 32'hFFF);
    @(posedge clk) terms.rst <= 1'b1;
    rd_reg("rst_wins", LBC_STATE_OFS, 32'hFFF, 32'h0);
    see("rst_fb", 1, 32'h2, 32'h0);
    @(posedge clk) terms <= '0;
    wr_reg(8'h08, mc(LBC_REG, 0, 1, 3, 0));
    @(posedge clk) terms.sum[2] <= 1'b1;
    pulse(3);
    see("t_set", 1, 32'h4, 32'h4);
    pulse(3);
    see("t_back", 1, 32'h4, 32'h0);
    @(posedge clk) terms.sum[2] <= 1'b0;
    pulse(3);
    see("t_hold", 1, 32'h4, 32'h0);
    wr_reg(8'h0C, mc(LBC_LATCH, 0, 0, 1, 0));
    @(posedge clk) terms.sum[3] <= 1'b1;
    see("latch_open", 1, 32'h8, 32'h8);
    @(posedge clk) cpin[1] <= 1'b1;
    repeat (2) @(posedge clk);
    terms.sum[3] <= 1'b0;
    see("latch_hold", 1, 32'h8, 32'h8);
    @(posedge clk) cpin[1] <= 1'b0;
    see("latch_pass", 1, 32'h8, 32'h0);
    wr_reg(8'h1C, mc(LBC_IN_REG, 0, 0, 0, 0));
    @(posedge clk) drv <= 6'h12;
    val <= 6'h12;
    see("in_wait", 1, 32'h80, 32'h0);
    pulse(0);
    see("in_reg", 1, 32'h80, 32'h80);
    rd_reg("pin_in", LBC_PIN_OFS, 32'h10, 32'h10);
    @(posedge clk) drv <= 6'h0;
    rd_reg("keeper", LBC_PIN_OFS, 32'h10, 32'h10);
    wr_reg(8'h30, 32'h1);
    wr_reg(8'h34, 32'h6);
    wr_reg(8'h38, 32'h2);
    @(posedge clk) terms.oe <= 2'b10;
    see("oe_t1", 3, 32'h7, 32'h4);
    @(posedge clk) terms.oe <= 2'b01;
    see("oe_t0", 3, 32'h7, 32'h2);
    results();
  end
endmodule : lbc_cell_slice_tb
